// ==== rtl/dpmm_buf_cell.sv ====
// one user I/O buffer cell with four selectable modes
// assumes the pad input is already synchronised by the caller
module dpmm_buf_cell (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire dpmm_pkg::dpmm_buf_mode_t mode,
  // user side
  input wire dpmm_pkg::dpmm_user_drive_t user,
  output logic user_in,
  // pad side
  input wire logic pad_in,
  output dpmm_pkg::dpmm_pad_drive_t pad
);

  wire logic drives;
  wire logic hears;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // input/output/tri/bidir modes
  assign drives = (mode == dpmm_pkg::DPMM_BUF_OUT) ||
                  (((mode == dpmm_pkg::DPMM_BUF_TRI) || (mode == dpmm_pkg::DPMM_BUF_BIDIR)) && user.en);
  assign hears = (mode == dpmm_pkg::DPMM_BUF_IN) || (mode == dpmm_pkg::DPMM_BUF_BIDIR);

  always_ff @(posedge clk) begin
    if (rst) begin
      pad <= '0;
      user_in <= 1'b0;
    end else begin
      pad.o <= drives ? user.data : 1'b0;
      pad.oe <= drives;
      user_in <= hears ? pad_in : 1'b0;
    end
  end

endmodule

// ==== rtl/dpmm_pkg.sv ====
// package for the diagnostic pin mode multiplexer
// assumes one 50 MHz clock domain and a synchronous active-high reset
package dpmm_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NODE_W = 16;
  localparam int SEL_W = 4;
  localparam int GPIO_N = 8;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
  localparam logic LOCK_RST = 1'b0;

  // ----------------------------------------
  // buffer mode encoding per general pin
  // ----------------------------------------
  typedef enum logic [1:0] {
    DPMM_BUF_IN = 2'b00,
    DPMM_BUF_OUT = 2'b01,
    DPMM_BUF_TRI = 2'b10,
    DPMM_BUF_BIDIR = 2'b11
  } dpmm_buf_mode_t;

  // one pad: output, output enable
  typedef struct packed {
    logic o;
    logic oe;
  } dpmm_pad_drive_t;

  // user-side request for a pad
  typedef struct packed {
    logic data;
    logic en;
  } dpmm_user_drive_t;

endpackage

// ==== rtl/dpmm_top.sv ====
// diagnostic pin mode multiplexer: four multifunction pins, clock pin, general I/O
// assumes pad inputs are asynchronous; one 50 MHz clock; sync active-high reset
module dpmm_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // mode select and lock request
  input wire logic mode_pin,
  input wire logic probe_kill,
  // internal nodes to observe
  input wire logic [dpmm_pkg::NODE_W-1:0] nodes,
  // global clock pin
  input wire logic gclk_pin_in,
  input wire logic gclk_as_io,
  output logic gclk_net,
  output logic gclk_user_in,
  // multifunction pads: 0 clock, 1 serial, 2 probe a, 3 probe b
  input wire logic [3:0] mf_pad_in,
  output logic [3:0] mf_pad_out,
  output logic [3:0] mf_pad_oe,
  input wire dpmm_pkg::dpmm_user_drive_t [3:0] mf_user,
  output logic [3:0] mf_user_in,
  // diagnostic side
  output logic diag_prog_clock,
  output logic diag_serial_in,
  output logic diag_active,
  output logic probe_locked,
  // general pins
  input wire dpmm_pkg::dpmm_buf_mode_t [dpmm_pkg::GPIO_N-1:0] gp_mode,
  input wire dpmm_pkg::dpmm_user_drive_t [dpmm_pkg::GPIO_N-1:0] gp_user,
  output logic [dpmm_pkg::GPIO_N-1:0] gp_user_in,
  input wire logic [dpmm_pkg::GPIO_N-1:0] gp_pad_in,
  output logic [dpmm_pkg::GPIO_N-1:0] gp_pad_out,
  output logic [dpmm_pkg::GPIO_N-1:0] gp_pad_oe
);

  typedef enum logic [1:0] {
    DPMM_ST_USER = 2'b00,
    DPMM_ST_DIAG = 2'b01,
    DPMM_ST_LOCK = 2'b10
  } dpmm_state_t;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [dpmm_pkg::GPIO_N-1:0] gp_sync1;
  logic [dpmm_pkg::GPIO_N-1:0] gp_sync2;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      gp_sync1 <= '0;
      gp_sync2 <= '0;
    end else begin
      sync1 <= {gclk_pin_in, probe_kill, mode_pin, mf_pad_in};
      sync2 <= sync1;
      gp_sync1 <= gp_pad_in;
      gp_sync2 <= gp_sync1;
    end
  end

  wire logic [3:0] mf_in_s = sync2[3:0];
  wire logic mode_s = sync2[4];
  wire logic kill_s = sync2[5];
  wire logic gclk_s = sync2[6];

  // ----------------------------------------
  // mode state
  // ----------------------------------------
  dpmm_state_t state;
  dpmm_state_t next_state;
  logic lock;

  always_comb begin
    next_state = state;
    case (state)
      DPMM_ST_USER: next_state = mode_s ? DPMM_ST_DIAG : DPMM_ST_USER;
      DPMM_ST_DIAG: next_state = mode_s ? DPMM_ST_DIAG : DPMM_ST_USER;
      DPMM_ST_LOCK: next_state = DPMM_ST_LOCK;
      default: next_state = DPMM_ST_USER;
    endcase
    if (kill_s) begin
      next_state = DPMM_ST_LOCK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DPMM_ST_USER;
      lock <= dpmm_pkg::LOCK_RST;
    end else begin
      state <= next_state;
      lock <= lock | kill_s;
    end
  end

  // special functions follow mode even when locked; only probes are blanked
  wire logic special = mode_s;
  wire logic probe_ok = special && !lock && !kill_s;

  // ----------------------------------------
  // serial probe selection, clocked by diagnostic clock edges
  // ----------------------------------------
  logic diag_clk_prev;
  logic [2*dpmm_pkg::SEL_W-1:0] sel_shift;
  wire logic diag_clk_rise = special && mf_in_s[0] && !diag_clk_prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      diag_clk_prev <= 1'b0;
      sel_shift <= {dpmm_pkg::SEL_RST, dpmm_pkg::SEL_RST};
    end else begin
      diag_clk_prev <= mf_in_s[0];
      if (diag_clk_rise) begin
        sel_shift <= {sel_shift[2*dpmm_pkg::SEL_W-2:0], mf_in_s[1]};
      end
    end
  end

  wire logic [dpmm_pkg::SEL_W-1:0] sel_a = sel_shift[2*dpmm_pkg::SEL_W-1:dpmm_pkg::SEL_W];
  wire logic [dpmm_pkg::SEL_W-1:0] sel_b = sel_shift[dpmm_pkg::SEL_W-1:0];
  wire logic node_a = nodes[sel_a];
  wire logic node_b = nodes[sel_b];

  // ----------------------------------------
  // multifunction pad muxing
  // ----------------------------------------
  logic [3:0] next_out;
  logic [3:0] next_oe;

  always_comb begin
    next_out = '0;
    next_oe = '0;
    for (int i = 0; i < 4; i++) begin
      next_oe[i] = !special && mf_user[i].en;
      next_out[i] = next_oe[i] ? mf_user[i].data : 1'b0;
    end
    // probes drive out in special mode unless locked or killed
    if (special) begin
      next_oe[2] = probe_ok;
      next_out[2] = probe_ok ? node_a : 1'b0;
      next_oe[3] = probe_ok;
      next_out[3] = probe_ok ? node_b : 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mf_pad_out <= '0;
      mf_pad_oe <= '0;
      mf_user_in <= '0;
      diag_prog_clock <= 1'b0;
      diag_serial_in <= 1'b0;
      diag_active <= 1'b0;
      probe_locked <= 1'b0;
      gclk_net <= 1'b0;
      gclk_user_in <= 1'b0;
    end else begin
      mf_pad_out <= next_out;
      mf_pad_oe <= next_oe;
      // probe pins readable as user I/O in user mode only; all four read 0 in special mode
      mf_user_in <= special ? 4'h0 : mf_in_s;
      diag_prog_clock <= special & mf_in_s[0];
      diag_serial_in <= special & mf_in_s[1];
      diag_active <= special;
      probe_locked <= lock | kill_s;
      // clock pin to network or as I/O
      gclk_net <= gclk_as_io ? 1'b0 : gclk_s;
      gclk_user_in <= gclk_as_io ? gclk_s : 1'b0;
    end
  end

  // ----------------------------------------
  // general pins
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < dpmm_pkg::GPIO_N; g++) begin : gp
      dpmm_pkg::dpmm_pad_drive_t drv;
      dpmm_buf_cell u_cell (
        .clk(clk),
        .rst(rst),
        .mode(gp_mode[g]),
        .user(gp_user[g]),
        .user_in(gp_user_in[g]),
        .pad_in(gp_sync2[g]),
        .pad(drv)
      );
      assign gp_pad_out[g] = drv.o;
      assign gp_pad_oe[g] = drv.oe;
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_probe_mode_a: assert property (@(posedge clk) disable iff (rst)
    (mode_s && !lock && !kill_s) |=> (mf_pad_oe[2] && mf_pad_out[2] == $past(node_a)))
    else $error("probe a not driven in diag mode");
  a_user_mode: assert property (@(posedge clk) disable iff (rst)
    !mode_s |=> (mf_pad_oe == $past({mf_user[3].en, mf_user[2].en, mf_user[1].en, mf_user[0].en})))
    else $error("user enables not passed in user mode");
  a_diag_clk_pass: assert property (@(posedge clk) disable iff (rst)
    (mode_s && mf_in_s[0]) |=> diag_prog_clock)
    else $error("diagnostic clock not passed");
  a_serial_shift: assert property (@(posedge clk) disable iff (rst)
    diag_clk_rise |=> sel_shift[0] == $past(mf_in_s[1]))
    else $error("serial bit not shifted");
  a_probe_b_node: assert property (@(posedge clk) disable iff (rst)
    (mode_s && !lock && !kill_s) |=> mf_pad_out[3] == $past(nodes[sel_b]))
    else $error("probe b wrong node");
  a_probe_user_in: assert property (@(posedge clk) disable iff (rst)
    !mode_s |=> mf_user_in[2] == $past(mf_in_s[2]))
    else $error("probe pin not readable as io");
  a_lock_sticky: assert property (@(posedge clk) disable iff (rst)
    probe_locked |=> probe_locked [*3])
    else $error("probe lock released");
  a_lock_blank: assert property (@(posedge clk) disable iff (rst)
    (lock && mode_s) |=> !mf_pad_oe[2] && !mf_pad_oe[3] && !mf_pad_out[2])
    else $error("locked probe driven");
  a_gclk_route: assert property (@(posedge clk) disable iff (rst)
    !gclk_as_io |=> gclk_net == $past(gclk_s) && !gclk_user_in)
    else $error("clock pin routing wrong");
  a_gp_input: assert property (@(posedge clk) disable iff (rst)
    gp_mode[0] == dpmm_pkg::DPMM_BUF_IN |=> !gp_pad_oe[0])
    else $error("input pin driving");

endmodule

// ==== test/dpmm_diag_tool.sv ====
// model of the external diagnostic tool: mode pin, diagnostic clock, serial data
// assumes the bench clock; every change lands just after a rising edge
module dpmm_diag_tool (
  // clock
  input wire logic clk,
  // pins toward the device
  output logic mode_pin,
  output logic diag_clk,
  output logic serial_bit,
  output logic drv
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mode_pin = 1'b0;
    diag_clk = 1'b0;
    serial_bit = 1'b0;
    drv = 1'b0;
  end

  task automatic enter();
    @(posedge clk);
    mode_pin <= 1'b1;
    drv <= 1'b1;
  endtask

  // released serial line must not keep its last value
  task automatic leave();
    @(posedge clk);
    mode_pin <= 1'b0;
    drv <= 1'b0;
    serial_bit <= ~serial_bit;
  endtask

  // clock stays low outside a frame, a-index msb first
  // at least four cycles per half so the device synchroniser sees each level
  task automatic shift(input logic [7:0] sel);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      serial_bit <= sel[i];
      repeat (4) @(posedge clk);
      diag_clk <= 1'b1;
      repeat (4) @(posedge clk);
      diag_clk <= 1'b0;
    end
  endtask
endmodule

// ==== test/test_diag_pin_mode_mux.sv ====
// self-checking bench for the diagnostic pin mode multiplexer
// assumes dpmm_top with three-edge pin latency and one-edge internal latency
module test_diag_pin_mode_mux;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic probe_kill = 1'b0;
  logic [dpmm_pkg::NODE_W-1:0] nodes = '0;
  logic gclk_pin_in = 1'b0;
  logic gclk_as_io = 1'b0;
  logic gclk_net, gclk_user_in;
  logic [3:0] bench_pad = 4'h0;
  logic [3:0] mf_pad_in, mf_pad_out, mf_pad_oe, mf_user_in;
  dpmm_pkg::dpmm_user_drive_t [3:0] mf_user = '0;
  logic diag_prog_clock, diag_serial_in, diag_active, probe_locked;
  dpmm_pkg::dpmm_buf_mode_t [dpmm_pkg::GPIO_N-1:0] gp_mode;
  dpmm_pkg::dpmm_user_drive_t [dpmm_pkg::GPIO_N-1:0] gp_user = '0;
  logic [dpmm_pkg::GPIO_N-1:0] gp_pad_in = '0;
  logic [dpmm_pkg::GPIO_N-1:0] gp_user_in, gp_pad_out, gp_pad_oe;
  logic mode_pin, tool_clk, tool_serial, tool_drv;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ----------------------------------------
  // clock, pads, instances
  // ----------------------------------------
  always #10 clk = ~clk;
  assign mf_pad_in = {bench_pad[3:2], tool_drv ? {tool_serial, tool_clk} : bench_pad[1:0]};

  dpmm_diag_tool tool_u (.clk(clk), .mode_pin(mode_pin), .diag_clk(tool_clk), .serial_bit(tool_serial),
    .drv(tool_drv));

  dpmm_top dut_u (.clk(clk), .rst(rst), .mode_pin(mode_pin), .probe_kill(probe_kill), .nodes(nodes),
    .gclk_pin_in(gclk_pin_in), .gclk_as_io(gclk_as_io), .gclk_net(gclk_net), .gclk_user_in(gclk_user_in),
    .mf_pad_in(mf_pad_in), .mf_pad_out(mf_pad_out), .mf_pad_oe(mf_pad_oe), .mf_user(mf_user),
    .mf_user_in(mf_user_in), .diag_prog_clock(diag_prog_clock), .diag_serial_in(diag_serial_in),
    .diag_active(diag_active), .probe_locked(probe_locked), .gp_mode(gp_mode), .gp_user(gp_user),
    .gp_user_in(gp_user_in), .gp_pad_in(gp_pad_in), .gp_pad_out(gp_pad_out), .gp_pad_oe(gp_pad_oe));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hang ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic user_mode();
    @(posedge clk);
    for (int i = 0; i < 4; i++) mf_user[i] <= {i[0], 1'b1};
    bench_pad <= 4'h6;
    settle(4);
    chk(mf_pad_out, 4'ha);
    chk(mf_pad_oe, 4'hf);
    chk(mf_user_in, 4'h6);
    chk(diag_active, 1'b0);
  endtask

  task automatic clk_pin();
    @(posedge clk);
    gclk_pin_in <= 1'b1;
    settle(4);
    chk({gclk_net, gclk_user_in}, 2'h2);
    @(posedge clk);
    gclk_as_io <= 1'b1;
    settle(4);
    chk({gclk_net, gclk_user_in}, 2'h1);
  endtask

  task automatic gp_modes();
    logic drive, reads;
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 2; e++) begin
        @(posedge clk);
        for (int i = 0; i < dpmm_pkg::GPIO_N; i++) begin
          gp_mode[i] <= dpmm_pkg::dpmm_buf_mode_t'(m);
          gp_user[i] <= {1'b1, e[0]};
        end
        gp_pad_in <= 8'h96;
        settle(4);
        drive = (m == 1) || (m >= 2 && e == 1);
        reads = (m == 0) || (m == 3);
        chk(gp_pad_oe, drive ? 8'hff : 8'h00);
        if (drive) chk(gp_pad_out, 8'hff);
        chk(gp_user_in, reads ? 8'h96 : 8'h00);
      end
    end
  endtask

  task automatic diag_probe();
    tool_u.enter();
    tool_u.shift(8'ha5);
    @(posedge clk);
    nodes <= 16'h0400;
    settle(4);
    chk(diag_active, 1'b1);
    chk(mf_pad_oe, 4'hc);
    chk(mf_user_in, 4'h0);
    chk(diag_serial_in, 1'b1);
    chk(diag_prog_clock, 1'b0);
    chk(mf_pad_out[3:2], 2'h1);
    @(posedge clk);
    nodes <= 16'h0020;
    settle(2);
    chk(mf_pad_out[3:2], 2'h2);
  endtask

  task automatic lock_probes();
    @(posedge clk);
    probe_kill <= 1'b1;
    nodes <= 16'hffff;
    @(posedge clk);
    probe_kill <= 1'b0;
    settle(4);
    chk(probe_locked, 1'b1);
    chk({mf_pad_oe[3:2], mf_pad_out[3:2]}, 4'h0);
    tool_u.leave();
    settle(4);
    chk(mf_pad_oe, 4'hf);
    chk(probe_locked, 1'b1);
  endtask

  // mid-run reset clears the lock and the probe selection
  task automatic reset_again();
    @(posedge clk);
    rst <= 1'b1;
    nodes <= 16'h0001;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk(probe_locked, 1'b0);
    chk(diag_active, 1'b0);
    tool_u.enter();
    settle(4);
    chk(mf_pad_oe[3:2], 2'h3);
    chk(mf_pad_out[3:2], 2'h3);
    tool_u.leave();
    settle(4);
    chk(diag_active, 1'b0);
  endtask

  initial begin
    for (int i = 0; i < dpmm_pkg::GPIO_N; i++) gp_mode[i] = dpmm_pkg::DPMM_BUF_IN;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    user_mode();
    clk_pin();
    gp_modes();
    diag_probe();
    lock_probes();
    reset_again();
    final_report();
  end
endmodule
